//--- src/ppbs_top.sv
// Push-pull PWM output stage with rising/falling edge input blanking.
// Assumes event sources arrive synchronous to clk_i; one clock domain.
//
// Behaviour
// [R1] Alternate pulses between outputs each period
// [R2] Odd period: primary follows rise/fall events
// [R3] Even period: secondary follows rise/fall events
// [R4] No dead-band delay in push-pull
// [R5] Output steering ignored, fixed mapping
// [R6] Waveform only on primary and secondary
// [R7] Rising blank source register, pin and comparators
// [R8] Falling blank source register, same layout
// [R9] Selected pin blocked during blanking time
// [R10] Selected comparators blocked during blanking time
// [R11] Unselected sources pass unblanked
// [R12] Bits 6, 5, 0 read zero
// [R13] Selection bits clear on reset
// [R14] Rise/fall events start blanking counters
// [R15] Blanking ends when counter equals time
// [R16] Blanking suppresses all event kinds alike
// [R17] Parity starts odd on enable, toggles
// [R18] Idle output held inactive whole period
`timescale 1ns/10ps
module ppbs_top #(
	parameter int CNT_W = 8
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic [ppbs_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [ppbs_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [ppbs_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                      external_event_pin_i,
	input  wire logic                      comparator_one_synced_i,
	input  wire logic                      comparator_two_synced_i,
	input  wire logic                      comparator_three_synced_i,
	input  wire logic                      comparator_four_synced_i,
	input  wire logic                      period_evt_i,
	input  wire logic                      rise_evt_i,
	input  wire logic                      fall_evt_i,
	input  wire logic [ppbs_pkg::NUM_SRC-1:0] src_rise_en_i,
	input  wire logic [ppbs_pkg::NUM_SRC-1:0] src_fall_en_i,
	input  wire logic [ppbs_pkg::NUM_SRC-1:0] src_per_en_i,
	input  wire logic [ppbs_pkg::NUM_SRC-1:0] src_shut_en_i,
	output logic                           primary_drive_out_o,
	output logic                           secondary_drive_out_o,
	output logic                           other_outs_o,
	output logic                           shutdown_o
);

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]       rise_blank_source_select_ff;
	logic [7:0]       fall_blank_source_select_ff;
	logic [7:0]       blanking_control_ff;
	logic [CNT_W-1:0] rise_blank_time_ff;
	logic [CNT_W-1:0] fall_blank_time_ff;
	logic [7:0]       rdata_ff;

	wire wr_rebs  = wr_i && (addr_i == ppbs_pkg::ADDR_REBS);
	wire wr_febs  = wr_i && (addr_i == ppbs_pkg::ADDR_FEBS);
	wire wr_ctrl  = wr_i && (addr_i == ppbs_pkg::ADDR_CTRL);
	wire wr_rtime = wr_i && (addr_i == ppbs_pkg::ADDR_RTIME);
	wire wr_ftime = wr_i && (addr_i == ppbs_pkg::ADDR_FTIME);

	wire enable   = blanking_control_ff[ppbs_pkg::CTRL_EN];
	wire rebm_on  = blanking_control_ff[ppbs_pkg::CTRL_REBM];
	wire febm_on  = blanking_control_ff[ppbs_pkg::CTRL_FEBM];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rise_blank_source_select_ff <= ppbs_pkg::BS_RESET; // [R13]
			fall_blank_source_select_ff <= ppbs_pkg::BS_RESET; // [R13]
			blanking_control_ff         <= ppbs_pkg::ZERO8;
			rise_blank_time_ff          <= '0;
			fall_blank_time_ff          <= '0;
		end else begin
			if (wr_rebs)
				rise_blank_source_select_ff <= wdata_i & ppbs_pkg::BS_MASK; // [R7] [R12]
			if (wr_febs)
				fall_blank_source_select_ff <= wdata_i & ppbs_pkg::BS_MASK; // [R8] [R12]
			if (wr_ctrl)
				blanking_control_ff <= wdata_i & ppbs_pkg::CTRL_MASK;
			if (wr_rtime)
				rise_blank_time_ff <= wdata_i[CNT_W-1:0];
			if (wr_ftime)
				fall_blank_time_ff <= wdata_i[CNT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Blanking counters
	logic             rblank_ff;
	logic             fblank_ff;
	logic [CNT_W-1:0] rcnt_ff;
	logic [CNT_W-1:0] fcnt_ff;

	// Pulse events from the timebase are accepted only while enabled
	wire rise_any;
	wire fall_any;
	wire per_any;

	wire r_start = rebm_on && rise_any; // [R14]
	wire f_start = febm_on && fall_any; // [R14]
	wire r_done  = rblank_ff && (rcnt_ff == rise_blank_time_ff); // [R15]
	wire f_done  = fblank_ff && (fcnt_ff == fall_blank_time_ff); // [R15]

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rblank_ff <= 1'b0;
			fblank_ff <= 1'b0;
			rcnt_ff   <= '0;
			fcnt_ff   <= '0;
		end else begin
			// Restart wins over termination so a new edge re-arms
			if (r_start) begin
				rblank_ff <= 1'b1;
				rcnt_ff   <= '0;
			end else if (r_done || !rebm_on) begin
				rblank_ff <= 1'b0; // [R15]
			end else if (rblank_ff) begin
				rcnt_ff <= rcnt_ff + 1'b1;
			end
			if (f_start) begin
				fblank_ff <= 1'b1;
				fcnt_ff   <= '0;
			end else if (f_done || !febm_on) begin
				fblank_ff <= 1'b0; // [R15]
			end else if (fblank_ff) begin
				fcnt_ff <= fcnt_ff + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source suppression, one lane per source
	wire [4:0] src_raw = {external_event_pin_i, comparator_four_synced_i,
		comparator_three_synced_i, comparator_two_synced_i,
		comparator_one_synced_i};
	wire [4:0] rsel = {rise_blank_source_select_ff[ppbs_pkg::BIT_PIN],
		rise_blank_source_select_ff[ppbs_pkg::BIT_CMP1+3:ppbs_pkg::BIT_CMP1]};
	wire [4:0] fsel = {fall_blank_source_select_ff[ppbs_pkg::BIT_PIN],
		fall_blank_source_select_ff[ppbs_pkg::BIT_CMP1+3:ppbs_pkg::BIT_CMP1]};
	logic [4:0] src_prev_ff;
	logic [4:0] src_edge;
	logic [4:0] src_lvl;

	genvar gi;
	generate
		for (gi = 0; gi < ppbs_pkg::NUM_SRC; gi++) begin : g_src
			wire blk = (rblank_ff && rsel[gi]) || (fblank_ff && fsel[gi]); // [R9] [R10]
			// Unselected lane passes straight through
			assign src_lvl[gi]  = src_raw[gi] && !blk; // [R11] [R16]
			assign src_edge[gi] = src_lvl[gi] && !src_prev_ff[gi];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			src_prev_ff <= '0;
		else
			src_prev_ff <= src_lvl;
	end

	// All event kinds see the same blanked lanes
	assign rise_any = enable && (rise_evt_i || |(src_edge & src_rise_en_i)); // [R16]
	assign fall_any = enable && (fall_evt_i || |(src_edge & src_fall_en_i)); // [R16]
	assign per_any  = enable && (period_evt_i || |(src_edge & src_per_en_i)); // [R16]
	wire   shut_any = enable && |(src_lvl & src_shut_en_i); // [R16]

	////////////////////////////////////////////////////////////////////////
	// Push-pull waveform
	logic parity_even_ff;
	logic primary_ff;
	logic secondary_ff;
	logic shutdown_ff;
	logic enable_d_ff;

	wire en_rise = enable && !enable_d_ff;
	// Rising on the same cycle as a period edge belongs to the new period
	wire even_now = per_any ? !parity_even_ff : parity_even_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			parity_even_ff <= 1'b0;
			enable_d_ff    <= 1'b0;
			primary_ff     <= 1'b0;
			secondary_ff   <= 1'b0;
			shutdown_ff    <= 1'b0;
		end else begin
			enable_d_ff <= enable;
			shutdown_ff <= shut_any;
			if (en_rise)
				parity_even_ff <= 1'b0; // [R17]
			else if (per_any)
				parity_even_ff <= !parity_even_ff; // [R1] [R17]
			if (!enable || shut_any) begin
				primary_ff   <= 1'b0;
				secondary_ff <= 1'b0;
			end else if (per_any) begin
				// Idle side cleared at each period boundary
				primary_ff   <= 1'b0; // [R18]
				secondary_ff <= 1'b0; // [R18]
				if (rise_any && !fall_any) begin
					primary_ff   <= !even_now;
					secondary_ff <= even_now;
				end
			end else if (fall_any) begin
				// No dead band: transitions land the same edge
				if (!even_now) primary_ff <= 1'b0; // [R2] [R4]
				else secondary_ff <= 1'b0; // [R3] [R4]
			end else if (rise_any) begin
				// Fixed mapping, no steering
				if (!even_now) primary_ff <= 1'b1; // [R2] [R5]
				else secondary_ff <= 1'b1; // [R3] [R5]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	wire [7:0] stat = {3'b000, secondary_ff, primary_ff, fblank_ff,
		rblank_ff, parity_even_ff};
	logic [7:0] rmux;
	always_comb begin
		case (addr_i)
			ppbs_pkg::ADDR_REBS:  rmux = rise_blank_source_select_ff; // [R12]
			ppbs_pkg::ADDR_FEBS:  rmux = fall_blank_source_select_ff; // [R12]
			ppbs_pkg::ADDR_CTRL:  rmux = blanking_control_ff;
			ppbs_pkg::ADDR_RTIME: rmux = 8'(rise_blank_time_ff);
			ppbs_pkg::ADDR_FTIME: rmux = 8'(fall_blank_time_ff);
			ppbs_pkg::ADDR_STAT:  rmux = stat;
			default:              rmux = ppbs_pkg::ZERO8;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_ff <= ppbs_pkg::ZERO8;
		else if (rd_i)
			rdata_ff <= rmux;
		else
			rdata_ff <= ppbs_pkg::ZERO8;
	end

	assign rdata_o               = rdata_ff;
	assign primary_drive_out_o   = primary_ff;
	assign secondary_drive_out_o = secondary_ff;
	assign other_outs_o          = 1'b0; // [R6]
	assign shutdown_o            = shutdown_ff;

endmodule // ppbs_top

//--- common/ppbs_pkg.sv
// Package for the push-pull PWM stage with input blanking select.
// Assumes a plain register port with 8-bit registers.
package ppbs_pkg;
	localparam int          ADDR_W         = 4;
	localparam int          DATA_W         = 8;
	localparam int          NUM_SRC        = 5;
	// Register indices (chosen offsets)
	localparam logic [3:0]  ADDR_REBS      = 4'h0;
	localparam logic [3:0]  ADDR_FEBS      = 4'h1;
	localparam logic [3:0]  ADDR_CTRL      = 4'h2;
	localparam logic [3:0]  ADDR_RTIME     = 4'h3;
	localparam logic [3:0]  ADDR_FTIME     = 4'h4;
	localparam logic [3:0]  ADDR_STAT      = 4'h5;
	// Blank source field positions
	localparam int          BIT_PIN        = 7;
	localparam int          BIT_CMP1       = 1;
	localparam logic [7:0]  BS_MASK        = 8'h9E;
	localparam logic [7:0]  BS_RESET       = 8'h00;
	// Control register bits
	localparam int          CTRL_EN        = 0;
	localparam int          CTRL_REBM      = 1;
	localparam int          CTRL_FEBM      = 2;
	localparam logic [7:0]  CTRL_MASK      = 8'h07;
	localparam logic [7:0]  ZERO8          = 8'h00;
	// Status register bits
	localparam int          ST_PARITY      = 0;
	localparam int          ST_RBLANK      = 1;
	localparam int          ST_FBLANK      = 2;
	localparam int          ST_PRI         = 3;
	localparam int          ST_SEC         = 4;
endpackage

//--- sim/ppbs_props.sv
// Port checker for the push-pull stage and its blank source registers.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/10ps
module ppbs_props #(
	parameter int CNT_W = 8
) (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       period_evt_i,
	input wire logic       rise_evt_i,
	input wire logic       fall_evt_i,
	input wire logic [4:0] src_fall_en_i,
	input wire logic       primary_drive_out_o,
	input wire logic       secondary_drive_out_o,
	input wire logic       other_outs_o,
	input wire logic       shutdown_o
);
	////////////////////////////////////////////////////////////////////////
	// Shadow of enable and both source selects, fed from bus writes
	logic [16:0] m_ff;
	wire  [7:0]  wm = wdata_i & ppbs_pkg::BS_MASK;
	wire         p = primary_drive_out_o;
	wire         s = secondary_drive_out_o;
	wire  [16:0] nxt_m = {
		(addr_i == ppbs_pkg::ADDR_CTRL) ? wdata_i[0] : m_ff[16],
		(addr_i == ppbs_pkg::ADDR_FEBS) ? wm : m_ff[15:8],
		(addr_i == ppbs_pkg::ADDR_REBS) ? wm : m_ff[7:0]};
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			m_ff <= 17'h0_0000;
		else if (wr_i)
			m_ff <= nxt_m;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// New period with a rise while one output is on
	sequence turn_s;
		(p || s) && period_evt_i && rise_evt_i && !fall_evt_i && m_ff[16]
			&& ~|src_fall_en_i && !shutdown_o ##1 !shutdown_o;
	endsequence
	sequence rise_s;
		rise_evt_i && m_ff[16] && !fall_evt_i && !period_evt_i
			&& ~|src_fall_en_i && !shutdown_o ##1 !shutdown_o;
	endsequence
	other_out_a: assert property (!other_outs_o)
		else $error("spare outputs not idle");
	one_out_a: assert property (!(p && s))
		else $error("both outputs on");
	shut_off_a: assert property (shutdown_o |-> !p && !s)
		else $error("output on during shutdown");
	rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	rise_src_a: assert property (
		rd_i && addr_i == ppbs_pkg::ADDR_REBS |=> rdata_o == m_ff[7:0])
		else $error("rise select readback wrong");
	fall_src_a: assert property (
		rd_i && addr_i == ppbs_pkg::ADDR_FEBS |=> rdata_o == m_ff[15:8])
		else $error("fall select readback wrong");
	rise_on_a: assert property (rise_s |-> p || s)
		else $error("rise event left outputs off");
	fall_off_a: assert property (
		fall_evt_i && m_ff[16] && !period_evt_i |=> !p && !s)
		else $error("fall event left an output on");
	off_idle_a: assert property (!m_ff[16] ##1 !m_ff[16] |-> !p && !s)
		else $error("output on while disabled");
	alt_out_a: assert property (turn_s |-> (p ^ s) && p == $past(s))
		else $error("outputs did not alternate");
endmodule // ppbs_props
bind ppbs_top ppbs_props #(.CNT_W(CNT_W)) u_props (.clk_i, .rst_n_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .period_evt_i, .rise_evt_i,
	.fall_evt_i, .src_fall_en_i, .primary_drive_out_o,
	.secondary_drive_out_o, .other_outs_o, .shutdown_o);

//--- sim/ppbs_front_model.sv
// Comparator bank and event pin beside the stage; lane 4 is the pin.
// Assumes one-cycle fire requests from the bench.
`timescale 1ns/10ps
module ppbs_front_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [4:0] fire_i,
	output logic            pin_o,
	output logic      [3:0] cmp_o
);
	// One-cycle trip per request, like a switching transient
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			{pin_o, cmp_o} <= 5'h00;
		else
			{pin_o, cmp_o} <= fire_i;
	end
endmodule // ppbs_front_model

//--- sim/ppbs_test.sv
// Self-checking bench for the push-pull stage with blanking select.
// Assumes the package register map and a one-clock design.
`timescale 1ns/10ps
module ppbs_test;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        per = 1'b0;
	logic        rise = 1'b0;
	logic        fall = 1'b0;
	logic [4:0]  ren = 5'h00;
	logic [4:0]  fen = 5'h00;
	logic [4:0]  fire = 5'h00;
	logic [4:0]  shen = 5'h00;
	logic [7:0]  rdata;
	logic [3:0]  cmp;
	logic        pin, pri, sec, oth;
	int          miscompares = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [31:0] seed = 32'h6688_86fe;
	wire  [7:0]  outs = {5'h00, oth, sec, pri};
	always #10 clk = ~clk;
	ppbs_front_model u_front (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire),
		.pin_o(pin), .cmp_o(cmp));
	ppbs_top #(.CNT_W(8)) DUT (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.external_event_pin_i(pin), .comparator_one_synced_i(cmp[0]),
		.comparator_two_synced_i(cmp[1]), .comparator_three_synced_i(cmp[2]),
		.comparator_four_synced_i(cmp[3]), .period_evt_i(per),
		.rise_evt_i(rise), .fall_evt_i(fall), .src_rise_en_i(ren),
		.src_fall_en_i(fen), .src_per_en_i(5'h00), .src_shut_en_i(shen),
		.primary_drive_out_o(pri), .secondary_drive_out_o(sec),
		.other_outs_o(oth), .shutdown_o());
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Selected lane holds its output; an open lane lets it change
	function automatic logic [7:0] exp_blk(input int m, input int s);
		return (s == m) ? 8'h00 : 8'h01;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Bits are period, fall, rise
	task automatic pulse(input logic [2:0] k);
		@(posedge clk);
		{per, fall, rise} <= k;
		@(posedge clk);
		{per, fall, rise} <= 3'b000;
		#1;
	endtask
	task automatic trip(input int k);
		@(posedge clk);
		fire <= 5'h01 << k;
		@(posedge clk);
		fire <= 5'h00;
		repeat (4) @(posedge clk);
		#1;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		logic [7:0] d;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd_reg(4'(i * 7) & 4'hF, v);
			chk(v, 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = (i == 0) ? 8'hFF : seed[7:0];
			wr_reg({3'b000, i[0]}, d);
			rd_reg({3'b000, i[0]}, v);
			chk(v, d & ppbs_pkg::BS_MASK);
		end
		wr_reg(4'h2, 8'h01);
		pulse(3'b001);
		chk(outs, 8'h01);
		pulse(3'b010);
		chk(outs, 8'h00);
		pulse(3'b101);
		chk(outs, 8'h02);
		pulse(3'b010);
		chk(outs, 8'h00);
		pulse(3'b100);
		pulse(3'b001);
		chk(outs, 8'h01);
		pulse(3'b101);
		chk(outs, 8'h02);
		wr_reg(4'h3, 8'h04);
		wr_reg(4'h4, 8'h04);
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 5; k++)
				for (int s = 0; s < 2; s++) begin
					d = (k == 4) ? 8'h80 : 8'h02 << k;
					wr_reg({3'b000, m[0]}, (s != 0) ? d : 8'h00);
					wr_reg(4'h2, 8'h00);
					wr_reg(4'h2, (m != 0) ? 8'h05 : 8'h03);
					ren <= (m != 0) ? 5'h01 << k : 5'h00;
					fen <= (m != 0) ? 5'h00 : 5'h01 << k;
					pulse(3'b001);
					if (m != 0)
						pulse(3'b010);
					trip(k);
					chk(outs, exp_blk(m, s));
					repeat (8) @(posedge clk);
					trip(k);
					chk(outs, {7'h00, m[0]});
				end
		// Blanked pin must not shut down; unblanked it must
		wr_reg(4'h0, 8'h80);
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h2, 8'h03);
		ren <= 5'h00;
		fen <= 5'h00;
		shen <= 5'h10;
		pulse(3'b001);
		trip(4);
		chk(outs, 8'h01);
		repeat (8) @(posedge clk);
		trip(4);
		chk(outs, 8'h00);
		close_out();
	end
endmodule // ppbs_test
